// file: hw/mscal_pkg.sv
package mscal_pkg;

  // ==========================================
  // register port map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_IDIRQ = 8'h04;
  localparam logic [7:0] ADDR_SRCFLAG = 8'h08;

  // ==========================================
  // control register write fields
  localparam int IMODE_SET_LO = 2;
  localparam int IMODE_CLR_LO = 10;
  localparam int SRC_EN_LO = 20;
  localparam int SRC_DIS_LO = 28;
  localparam int NUM_SRC = 4;

  // ==========================================
  // id/irq register fields
  localparam int VEC_LO = 0;
  localparam int VEC_W = 8;
  localparam int LVL_LO = 8;
  localparam int LVL_W = 3;
  localparam int GIE_BIT = 11;
  localparam int VER_LO = 12;
  localparam int ID_LO = 16;
  // identity values are arbitrary
  localparam logic [15:0] MODULE_ID = 16'h0abc;
  localparam logic [3:0] MODULE_VER = 4'h1;

  // ==========================================
  // data word layout
  localparam int CNT24_W = 24;
  localparam int CHAN_W = 5;
  localparam int HALF_W = 16;

  // ==========================================
  // interrupt source indices
  localparam int SRC_CIP = 0;
  localparam int SRC_HALF = 1;
  localparam int SRC_AFULL = 2;
  localparam int SRC_FULL = 3;

  typedef enum logic [1:0] {
    IMODE_NEXT_USER,
    IMODE_NEXT_DIS,
    IMODE_NEXT_DIS4,
    IMODE_TEST
  } imode_t;

endpackage

// file: hw/src_latch.sv
`timescale 1ns/1ps
module src_latch
  import mscal_pkg::*;
(
  // clock
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // control
  input wire logic cause_i,
  input wire logic enable_i,
  // state
  output logic flag_o
);
  logic flag_q;
  logic flag_d;

  // held while cause present; dropped only when disabled and cause is gone
  always_comb begin
    flag_d = flag_q;
    if (!enable_i && !cause_i) begin
      flag_d = 1'b0;
    end
    if (enable_i && cause_i) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flag_q <= 1'b0;
    end else if (ce_i) begin
      flag_q <= flag_d;
    end
  end

  assign flag_o = flag_q;
endmodule

// file: hw/word_fmt.sv
`timescale 1ns/1ps
module word_fmt
  import mscal_pkg::*;
(
  // selection
  input wire logic mode24_i,
  input wire logic second_half_i,
  // fields
  input wire logic [31:0] count_i,
  input wire logic [1:0] user_i,
  input wire logic bank_i,
  input wire logic [CHAN_W-1:0] chan_i,
  // result
  output logic [31:0] word_o,
  output logic [HALF_W-1:0] half_o
);
  // tag byte: user1, user0, bank, channel msb..lsb
  always_comb begin
    word_o = count_i;
    if (mode24_i) begin
      word_o = {user_i[1], user_i[0], bank_i, chan_i, count_i[CNT24_W-1:0]};
    end
    half_o = second_half_i ? word_o[HALF_W-1:0] : word_o[31:HALF_W];
  end
endmodule

// file: hw/mscal_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - four sources: copy start, half full, almost full, full (error)
// - release-on-acknowledge interrupter returning only an 8-bit vector
// - with four fifo chips almost full replaces half full as cause
// - a source interrupts only after its enable bit; its disable bit clears it only once the cause has gone
// - bus request only while global enable bit 11 is one
// - internal flag readable by software even without bus request
// - level from bits 8-10, vector from bits 0-7
// - 32-bit mode: raw counter; 16-bit reads give high half then low
// - 24-bit mode: low 24 bits count, top byte tag
// - tag byte: user1, user0, bank, five-bit channel; first half read
// - mode 0: next, user1, user2, reset or step inhibit
// - mode 1: next, user1, disable counting, reset or step inhibit
// - mode 2: next, user1, user2, disable counting on input 4
// - mode 3: input 4 is external test pulse
// - lines 5-8 out: copy, empty, half full, full
// - counting inhibited while disable input held
// - 24-bit mode latches user bits on leading edge of next
// - acknowledge drives vector onto low eight data lines
// - ctrl write bits 20-23 enable, 28-31 disable sources
// - ctrl write bits 2,3 set mode bits, 10,11 clear them
module mscal_ctrl
  import mscal_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // interrupt bus
  input wire logic iack_i,
  output logic [LVL_W-1:0] irq_level_o,
  output logic irq_req_o,
  output logic [VEC_W-1:0] iack_data_o,
  output logic iack_data_oe_o,
  // configuration
  input wire logic mode24_i,
  input wire logic four_fifo_i,
  input wire logic new_version_i,
  // fifo and copy status
  input wire logic copy_in_progress_i,
  input wire logic fifo_empty_i,
  input wire logic fifo_half_i,
  input wire logic fifo_almost_empty_i,
  input wire logic fifo_full_i,
  // front panel control inputs 1..4
  input wire logic [3:0] ctl_in_i,
  // data formatting
  input wire logic [31:0] count_i,
  input wire logic bank_i,
  input wire logic [CHAN_W-1:0] chan_i,
  input wire logic second_half_i,
  output logic [31:0] data_word_o,
  output logic [HALF_W-1:0] data_half_o,
  // decoded control functions
  output logic step_advance_pulse_o,
  output logic count_inhibit_o,
  output logic ext_reset_o,
  output logic step_inhibit_o,
  output logic ext_test_o,
  output logic [1:0] user_tag_o,
  // front panel outputs 5..8
  output logic [3:0] ctl_out_o
);

  // ==========================================
  // register state
  logic [NUM_SRC-1:0] src_en_q, src_en_d;
  logic [1:0] imode_q, imode_d;
  logic [VEC_W-1:0] vec_q, vec_d;
  logic [LVL_W-1:0] lvl_q, lvl_d;
  logic gie_q, gie_d;
  logic [31:0] rdata_q, rdata_d;

  logic [NUM_SRC-1:0] src_flag;
  logic [NUM_SRC-1:0] cause;
  logic any_flag;
  imode_t imode;

  assign imode = imode_t'(imode_q);

  always_comb begin
    src_en_d = src_en_q;
    imode_d = imode_q;
    vec_d = vec_q;
    lvl_d = lvl_q;
    gie_d = gie_q;
    rdata_d = rdata_q;
    if (reg_wr_i && reg_addr_i == ADDR_CTRL) begin
      // disable wins if both written together
      src_en_d = (src_en_q | reg_wdata_i[SRC_EN_LO +: NUM_SRC])
                 & ~reg_wdata_i[SRC_DIS_LO +: NUM_SRC];
      imode_d = (imode_q | reg_wdata_i[IMODE_SET_LO +: 2])
                & ~reg_wdata_i[IMODE_CLR_LO +: 2];
    end
    if (reg_wr_i && reg_addr_i == ADDR_IDIRQ) begin
      vec_d = reg_wdata_i[VEC_LO +: VEC_W];
      lvl_d = reg_wdata_i[LVL_LO +: LVL_W];
      gie_d = reg_wdata_i[GIE_BIT];
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_CTRL: rdata_d = {8'h00, src_en_q, 4'h0, 4'h0, 4'h0, 4'h0, imode_q, 2'h0};
        ADDR_IDIRQ: rdata_d = {MODULE_ID, MODULE_VER, gie_q, lvl_q, vec_q};
        ADDR_SRCFLAG: rdata_d = {23'h000000, any_flag, 4'h0, src_flag};
        default: rdata_d = 32'h0000_0000;
      endcase
    end else begin
      rdata_d = 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      src_en_q <= '0;
      imode_q <= 2'h0;
      vec_q <= 8'h00;
      lvl_q <= 3'h0;
      gie_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (ce_i) begin
      src_en_q <= src_en_d;
      imode_q <= imode_d;
      vec_q <= vec_d;
      lvl_q <= lvl_d;
      gie_q <= gie_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================
  // interrupt sources
  logic cip_prev_q, cip_prev_d;
  logic afull_raw;

  // almost full with four chips = almost empty has cleared (~25-50% fill)
  assign afull_raw = four_fifo_i ? !fifo_almost_empty_i : fifo_half_i;

  always_comb begin
    cip_prev_d = copy_in_progress_i;
    cause[SRC_CIP] = copy_in_progress_i && !cip_prev_q;
    cause[SRC_HALF] = fifo_half_i && !four_fifo_i;
    cause[SRC_AFULL] = afull_raw;
    cause[SRC_FULL] = fifo_full_i;
  end

  for (genvar s = 0; s < NUM_SRC; s++) begin : g_src
    src_latch u_src (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .cause_i(cause[s]),
      .enable_i(src_en_q[s]),
      .flag_o(src_flag[s])
    );
  end

  assign any_flag = |src_flag;

  // ==========================================
  // bus request and acknowledge
  logic req_q, req_d;
  logic [VEC_W-1:0] ackd_q, ackd_d;
  logic ackoe_q, ackoe_d;
  logic acked_q, acked_d;

  // released on acknowledge; rearmed once all flags have been cleared
  always_comb begin
    acked_d = acked_q;
    if (req_q && iack_i) begin
      acked_d = 1'b1;
    end else if (!any_flag) begin
      acked_d = 1'b0;
    end
    req_d = any_flag && gie_q && !acked_d && lvl_q != 3'h0;
    ackoe_d = req_q && iack_i;
    ackd_d = ackoe_d ? vec_q : 8'h00;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cip_prev_q <= 1'b0;
      req_q <= 1'b0;
      ackd_q <= 8'h00;
      ackoe_q <= 1'b0;
      acked_q <= 1'b0;
    end else if (ce_i) begin
      cip_prev_q <= cip_prev_d;
      req_q <= req_d;
      ackd_q <= ackd_d;
      ackoe_q <= ackoe_d;
      acked_q <= acked_d;
    end
  end

  // ==========================================
  // control input decode and outputs
  logic next_prev_q, next_prev_d;
  logic [1:0] user_q, user_d;
  logic step_q, step_d, inh_q, inh_d, rst_q, rst_d, sinh_q, sinh_d, test_q, test_d;
  logic [3:0] out_q, out_d;
  logic [31:0] word_c;
  logic [HALF_W-1:0] half_c;
  logic [31:0] word_q;
  logic [HALF_W-1:0] half_q;

  always_comb begin
    next_prev_d = ctl_in_i[0];
    user_d = user_q;
    step_d = 1'b0;
    inh_d = 1'b0;
    rst_d = 1'b0;
    sinh_d = 1'b0;
    test_d = 1'b0;
    unique case (imode)
      IMODE_NEXT_USER: begin
        step_d = ctl_in_i[0] && !next_prev_q;
        rst_d = ctl_in_i[3] && !new_version_i;
        sinh_d = ctl_in_i[3] && new_version_i;
      end
      IMODE_NEXT_DIS: begin
        step_d = ctl_in_i[0] && !next_prev_q;
        inh_d = ctl_in_i[2];
        rst_d = ctl_in_i[3] && !new_version_i;
        sinh_d = ctl_in_i[3] && new_version_i;
      end
      IMODE_NEXT_DIS4: begin
        step_d = ctl_in_i[0] && !next_prev_q;
        inh_d = ctl_in_i[3];
      end
      IMODE_TEST: begin
        test_d = ctl_in_i[3];
      end
    endcase
    if (step_d && mode24_i) begin
      user_d[1] = ctl_in_i[1];
      user_d[0] = (imode == IMODE_NEXT_DIS) ? 1'b0 : ctl_in_i[2];
    end
    out_d = {fifo_full_i, fifo_half_i, fifo_empty_i, copy_in_progress_i};
  end

  word_fmt u_fmt (
    .mode24_i(mode24_i),
    .second_half_i(second_half_i),
    .count_i(count_i),
    .user_i(user_q),
    .bank_i(bank_i),
    .chan_i(chan_i),
    .word_o(word_c),
    .half_o(half_c)
  );

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      next_prev_q <= 1'b0;
      user_q <= 2'h0;
      step_q <= 1'b0;
      inh_q <= 1'b0;
      rst_q <= 1'b0;
      sinh_q <= 1'b0;
      test_q <= 1'b0;
      out_q <= 4'h0;
      word_q <= 32'h0000_0000;
      half_q <= 16'h0000;
    end else if (ce_i) begin
      next_prev_q <= next_prev_d;
      user_q <= user_d;
      step_q <= step_d;
      inh_q <= inh_d;
      rst_q <= rst_d;
      sinh_q <= sinh_d;
      test_q <= test_d;
      out_q <= out_d;
      word_q <= word_c;
      half_q <= half_c;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign irq_level_o = lvl_q;
  assign irq_req_o = req_q;
  assign iack_data_o = ackd_q;
  assign iack_data_oe_o = ackoe_q;
  assign data_word_o = word_q;
  assign data_half_o = half_q;
  assign step_advance_pulse_o = step_q;
  assign count_inhibit_o = inh_q;
  assign ext_reset_o = rst_q;
  assign step_inhibit_o = sinh_q;
  assign ext_test_o = test_q;
  assign user_tag_o = user_q;
  assign ctl_out_o = out_q;

  // ==========================================
  // checks
  sequence s_ack;
    req_q && iack_i;
  endsequence

  irq_gate_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    irq_req_o |-> $past(gie_q)) else $error("request without global enable");
  ack_vector_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (ce_i and s_ack) |=> iack_data_oe_o && iack_data_o == $past(vec_q))
    else $error("acknowledge vector wrong");
  ack_release_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (ce_i and s_ack) ##1 ce_i |=> !irq_req_o) else $error("request not released");
  src_enable_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    ce_i && reg_wr_i && reg_addr_i == ADDR_CTRL && reg_wdata_i[SRC_DIS_LO]
    |=> !src_en_q[0]) else $error("source disable ignored");
  mode_set_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    ce_i && reg_wr_i && reg_addr_i == ADDR_CTRL && reg_wdata_i[IMODE_SET_LO]
    && !reg_wdata_i[IMODE_CLR_LO] |=> imode_q[0]) else $error("mode bit not set");
  flag_hold_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    ce_i && src_flag[SRC_FULL] && src_en_q[SRC_FULL] |=> src_flag[SRC_FULL])
    else $error("flag lost while enabled");
  outputs_map_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    ce_i |=> ctl_out_o[3] == $past(fifo_full_i) && ctl_out_o[0] == $past(copy_in_progress_i))
    else $error("control output mapping");
  inhibit_map_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    ce_i && imode == IMODE_NEXT_DIS4 && ctl_in_i[3] |=> count_inhibit_o)
    else $error("disable counting missing");
endmodule

// file: bench/irq_master_model.sv
`timescale 1ns/1ps
// ======
// interrupt handler side of the bus
module irq_master_model (
  // clock
  input wire logic clk_i,
  input wire logic rst_i,
  // request from the device
  input wire logic irq_req_i,
  input wire logic [2:0] irq_level_i,
  input wire logic [7:0] iack_data_i,
  input wire logic iack_data_oe_i,
  // cycles spent before acknowledging
  input wire logic [3:0] delay_i,
  // acknowledge and capture
  output logic iack_o,
  output logic [2:0] level_o,
  output logic [7:0] vector_o,
  output int n_ack_o
);
  initial begin
    iack_o = 1'b0;
    level_o = 3'h0;
    vector_o = 8'h00;
    n_ack_o = 0;
    forever begin
      @(posedge clk_i);
      if (!rst_i && irq_req_i === 1'b1) begin
        level_o <= irq_level_i;
        repeat (delay_i) @(posedge clk_i);
        // held until the vector is offered, bounded so a dead device cannot hang us
        iack_o <= 1'b1;
        for (int k = 0; k < 16 && iack_data_oe_i !== 1'b1; k++) @(posedge clk_i);
        vector_o <= iack_data_i;
        iack_o <= 1'b0;
        n_ack_o <= n_ack_o + 1;
      end
    end
  end
endmodule

// file: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import mscal_pkg::*;
  // ======
  // stimulus and observed signals
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic mode24_i = 1'b0;
  logic four_fifo_i = 1'b0;
  logic new_version_i = 1'b0;
  logic [4:0] st = 5'h08; // full, almost empty, half, empty, copy
  logic [3:0] ctl_in_i = 4'h0;
  logic [31:0] count_i = 32'h0;
  logic bank_i = 1'b0;
  logic second_half_i = 1'b0;
  logic [CHAN_W-1:0] chan_i = 5'h00;
  logic [3:0] dly = 4'h0;
  logic [31:0] seed = 32'hcb84;
  logic [31:0] reg_rdata_o, data_word_o;
  logic [LVL_W-1:0] irq_level_o, p_lvl;
  logic [VEC_W-1:0] iack_data_o, p_vec;
  logic [HALF_W-1:0] data_half_o;
  logic [3:0] dec, ctl_out_o;
  logic [1:0] user_tag_o;
  logic irq_req_o, iack_data_oe_o, iack_i, step_advance_pulse_o;
  int n_ack, mismatches = 0, n_tests = 0, cycles = 0;

  mscal_ctrl i_mscal_ctrl (.core_clk_i, .sys_rst_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .iack_i, .irq_level_o, .irq_req_o, .iack_data_o, .iack_data_oe_o,
    .mode24_i, .four_fifo_i, .new_version_i, .copy_in_progress_i(st[0]), .fifo_empty_i(st[1]),
    .fifo_half_i(st[2]), .fifo_almost_empty_i(st[3]), .fifo_full_i(st[4]), .ctl_in_i, .count_i,
    .bank_i, .chan_i, .second_half_i, .data_word_o, .data_half_o, .step_advance_pulse_o,
    .count_inhibit_o(dec[3]), .ext_reset_o(dec[2]), .step_inhibit_o(dec[1]), .ext_test_o(dec[0]),
    .user_tag_o, .ctl_out_o);

  irq_master_model i_irq_master_model (.clk_i(core_clk_i), .rst_i(sys_rst_i),
    .irq_req_i(irq_req_o), .irq_level_i(irq_level_o), .iack_data_i(iack_data_o),
    .iack_data_oe_i(iack_data_oe_o), .delay_i(dly), .iack_o(iack_i), .level_o(p_lvl),
    .vector_o(p_vec), .n_ack_o(n_ack));

  always #12.5 core_clk_i = ~core_clk_i;

  // ======
  // helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // {inhibit, reset, step inhibit, test} expected from mode, version and inputs
  function automatic logic [3:0] exp_dec(logic [1:0] m, logic v, logic [3:0] c);
    logic [3:0] e;
    e = 4'h0;
    if (m == 2'd1) e[3] = c[2];
    if (m == 2'd2) e[3] = c[3];
    if (m < 2'd2) e[v ? 1 : 2] = c[3];
    if (m == 2'd3) e[0] = c[3];
    return e;
  endfunction

  task cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #2;
    chk(reg_rdata_o, exp);
  endtask

  task wait_ack(input int n);
    int k;
    k = 0;
    while (n_ack != n && k < 100) begin
      cyc(1);
      k++;
    end
    chk(32'(n_ack), 32'(n));
  endtask

  task end_sim();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // a hang counts as a mismatch
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  // ======
  // scenarios
  initial begin
    logic [31:0] r, w;
    logic [7:0] vec;
    logic [2:0] lvl;
    logic [1:0] m;
    int hi;
    repeat (16) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_IDIRQ, {MODULE_ID, MODULE_VER, 12'h000});
    rd(ADDR_SRCFLAG, 32'h0);
    rd(8'h0c, 32'h0);
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      st <= r[4:0];
      cyc(3);
      chk(32'(ctl_out_o), {28'h0, r[4], r[2], r[1], r[0]});
    end
    // clock enable low must freeze the registered outputs
    ce_i <= 1'b0;
    st <= ~r[4:0];
    cyc(3);
    chk(32'(ctl_out_o), {28'h0, r[4], r[2], r[1], r[0]});
    ce_i <= 1'b1;
    st <= 5'h08;
    for (int k = 0; k < 4; k++) begin
      m = k[1:0];
      wr(ADDR_CTRL, {20'h0, ~m, 6'h00, m, 2'b00});
      rd(ADDR_CTRL, {28'h0, m, 2'b00});
      for (int j = 0; j < 6; j++) begin
        r = rnd();
        ctl_in_i <= r[3:0];
        new_version_i <= r[4];
        cyc(3);
        chk(32'(dec), 32'(exp_dec(m, r[4], r[3:0])));
      end
      ctl_in_i <= 4'h0;
      cyc(2);
      ctl_in_i <= 4'h1;
      hi = 0;
      repeat (5) begin
        cyc(1);
        if (step_advance_pulse_o === 1'b1) hi++;
      end
      chk(32'(hi), (m == 2'd3) ? 32'h0 : 32'h1);
    end
    wr(ADDR_CTRL, 32'h0000_0c00);
    for (int j = 0; j < 8; j++) begin
      r = rnd();
      mode24_i <= 1'b1;
      ctl_in_i <= {1'b0, r[1], r[0], 1'b0};
      cyc(2);
      ctl_in_i[0] <= 1'b1;
      cyc(3);
      chk(32'(user_tag_o), {30'h0, r[0], r[1]});
      count_i <= rnd();
      bank_i <= r[2];
      chan_i <= r[7:3];
      second_half_i <= r[8];
      mode24_i <= r[9];
      cyc(2);
      w = r[9] ? {r[0], r[1], r[2], r[7:3], count_i[23:0]} : count_i;
      chk(data_word_o, w);
      chk(32'(data_half_o), r[8] ? {16'h0, w[15:0]} : {16'h0, w[31:16]});
    end
    // full fifo, slow handler
    r = rnd();
    vec = r[7:0];
    lvl = (r[10:8] == 3'd0) ? 3'd1 : r[10:8];
    wr(ADDR_IDIRQ, {20'h0, 1'b1, lvl, vec});
    rd(ADDR_IDIRQ, {MODULE_ID, MODULE_VER, 1'b1, lvl, vec});
    wr(ADDR_CTRL, 32'h0080_0000);
    dly <= 4'h6;
    st[4] <= 1'b1;
    wait_ack(1);
    chk(32'(p_lvl), 32'(lvl));
    chk(32'(p_vec), 32'(vec));
    cyc(4);
    chk(32'(irq_req_o), 32'h0);
    rd(ADDR_SRCFLAG, 32'h0000_0108);
    // clearing order: disable, remove cause, re-enable
    wr(ADDR_CTRL, 32'h8000_0000);
    st[4] <= 1'b0;
    cyc(2);
    wr(ADDR_CTRL, 32'h0080_0000);
    rd(ADDR_SRCFLAG, 32'h0);
    chk(32'(irq_req_o), 32'h0);
    // transient copy start with requests globally off, then prompt handler
    wr(ADDR_IDIRQ, {20'h0, 1'b0, lvl, vec});
    wr(ADDR_CTRL, 32'h0010_0000);
    st[0] <= 1'b1;
    cyc(1);
    st[0] <= 1'b0;
    cyc(6);
    chk(32'(irq_req_o), 32'h0);
    rd(ADDR_SRCFLAG, 32'h0000_0101);
    dly <= 4'h0;
    wr(ADDR_IDIRQ, {20'h0, 1'b1, lvl, vec});
    wait_ack(2);
    wr(ADDR_CTRL, 32'h9000_0000);
    rd(ADDR_SRCFLAG, 32'h0);
    // four fifo chips: almost full replaces half full
    wr(ADDR_IDIRQ, {20'h0, 1'b0, lvl, vec});
    four_fifo_i <= 1'b1;
    st <= 5'h0c;
    wr(ADDR_CTRL, 32'h0060_0000);
    rd(ADDR_CTRL, 32'h0060_0000);
    cyc(3);
    rd(ADDR_SRCFLAG, 32'h0);
    st[3] <= 1'b0;
    cyc(3);
    rd(ADDR_SRCFLAG, 32'h0000_0104);
    wr(ADDR_CTRL, 32'h2020_0000);
    rd(ADDR_CTRL, 32'h0040_0000);
    wr(8'h0c, 32'hffff_ffff);
    rd(ADDR_CTRL, 32'h0040_0000);
    end_sim();
  end
endmodule
